// ===== bsm_setting_monitor_bank.v
// AXI4-Lite register bank mirroring the active bridge settings and the parameter init command.
//
// Behaviour
// - Word cycle count is read back live.
// - Word cycles read zero without word transmission.
// - Startup mode reads zero or one.
// - Full double check reads 0000 or 0020.
// - Value n checks words one through n.
// - Auto recovery mode reads zero or one.
// - Word input fault policy reads zero/one.
// - Output fault policy reads zero or one.
// - Easy replacement reads zero enabled, one disabled.
// - Command bit zero erases and restores memory.
// - Command bit zero resets to no command.
// - Nonzero fixed bits raise no error.
// - New values appear only after power cycle.
// - Completion bit zero set when init finishes.
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "bsm_defs.vh"

module bsm_setting_monitor_bank #(
   parameter ADDR_W = 16
) (
   input wire ref_clk_in,
   input wire rst_in,
   // Active settings latched by the device at power-up.
   input wire word_tx_used_in,
   input wire [15:0] word_cycles_in,
   input wire startup_collect_in,
   input wire [15:0] dbl_check_in,
   input wire auto_recovery_in,
   input wire word_in_hold_in,
   input wire out_hold_in,
   input wire easy_swap_disable_in,
   // Non-volatile memory erase handshake.
   input wire nvm_init_done_in,
   output reg nvm_init_req_out,
   output reg irq_out,
   // AXI4-Lite slave.
   input wire [ADDR_W-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [ADDR_W-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready
);

   // ------------------------------------------------------------
   // Local constants
   // ------------------------------------------------------------
   // States of the erase sequencer.
   localparam ST_IDLE = 1'b0;
   localparam ST_BUSY = 1'b1;
   // Slots of the one-bit setting words, in register order.
   localparam NUM_FLAGS = 5;
   localparam FLAG_STARTUP = 0;
   localparam FLAG_AUTO_RECOV = 1;
   localparam FLAG_IN_POLICY = 2;
   localparam FLAG_OUT_POLICY = 3;
   localparam FLAG_EASY_SWAP = 4;

   // ------------------------------------------------------------
   // Write side declarations
   // ------------------------------------------------------------
   reg aw_held_r;
   reg [ADDR_W-1:0] aw_addr_r;
   reg w_held_r;
   reg [15:0] w_data_r;
   reg [1:0] w_strb_r;

   reg init_state_r;
   reg init_state_nxt;
   reg init_done_r;
   reg init_done_nxt;

   reg [`BSM_IRQ_W-1:0] irq_stat_r;
   reg [`BSM_IRQ_W-1:0] irq_stat_nxt;
   reg [`BSM_IRQ_W-1:0] irq_mask_r;
   reg [`BSM_IRQ_W-1:0] irq_set;
   reg [`BSM_IRQ_W-1:0] irq_clr;

   wire [ADDR_W-1:0] wr_addr;
   wire [ADDR_W-3:0] wr_idx;
   wire [15:0] w_eff_data;
   wire [1:0] w_eff_strb;
   wire aw_fire;
   wire w_fire;
   wire b_fire;
   wire do_write;
   wire hit_w;
   wire cmd_wr;
   wire init_busy;
   wire init_finish;
   wire mask_wr;
   wire stat_wr;

   // ------------------------------------------------------------
   // Write decode
   // ------------------------------------------------------------
   // A beat that arrives alone is parked until its partner shows up.
   assign aw_fire = s_axi_awvalid & s_axi_awready;
   assign w_fire = s_axi_wvalid & s_axi_wready;
   assign b_fire = s_axi_bvalid & s_axi_bready;
   assign wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
   assign wr_idx = wr_addr[ADDR_W-1:2];
   assign w_eff_data = w_held_r ? w_data_r : s_axi_wdata[15:0];
   assign w_eff_strb = w_held_r ? w_strb_r : s_axi_wstrb[1:0];
   assign do_write = (aw_held_r | aw_fire) & (w_held_r | w_fire) & ~s_axi_bvalid;
   // Read-back words accept writes so that a host sweep sees no error.
   assign hit_w = (wr_idx >= `BSM_IDX_WORD_CYCLES && wr_idx <= `BSM_IDX_EASY_SWAP) ||
      (wr_idx >= `BSM_IDX_INIT_CMD && wr_idx <= `BSM_IDX_IRQ_MASK);
   assign cmd_wr = do_write && wr_idx == `BSM_IDX_INIT_CMD && w_eff_strb[0] &&
      w_eff_data[`BSM_CMD_BIT];
   assign mask_wr = do_write && wr_idx == `BSM_IDX_IRQ_MASK && w_eff_strb[0];
   assign stat_wr = do_write && wr_idx == `BSM_IDX_IRQ_STATUS && w_eff_strb[0];
   assign init_busy = (init_state_r == ST_BUSY);
   assign init_finish = init_busy & nvm_init_done_in;

   // ------------------------------------------------------------
   // Write address capture
   // ------------------------------------------------------------
   always @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         s_axi_awready <= 1'b0;
         aw_held_r <= 1'b0;
         aw_addr_r <= {ADDR_W{1'b0}};
      end else if (do_write) begin
         // The beat is consumed; ready stays low until the response is gone.
         s_axi_awready <= 1'b0;
         aw_held_r <= 1'b0;
      end else begin
         // Ready is offered only while nothing is pending on this channel.
         s_axi_awready <= ~aw_held_r & ~aw_fire & ~s_axi_bvalid;
         if (aw_fire) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
      end
   end

   // ------------------------------------------------------------
   // Write data capture
   // ------------------------------------------------------------
   always @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         s_axi_wready <= 1'b0;
         w_held_r <= 1'b0;
         w_data_r <= 16'h0000;
         w_strb_r <= 2'b00;
      end else if (do_write) begin
         s_axi_wready <= 1'b0;
         w_held_r <= 1'b0;
      end else begin
         s_axi_wready <= ~w_held_r & ~w_fire & ~s_axi_bvalid;
         if (w_fire) begin
            w_held_r <= 1'b1;
            // Only the low half carries a field; the upper half is dropped.
            w_data_r <= s_axi_wdata[15:0];
            w_strb_r <= s_axi_wstrb[1:0];
         end
      end
   end

   // ------------------------------------------------------------
   // Write response
   // ------------------------------------------------------------
   always @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `BSM_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         // Read-back words accept the write with OKAY but keep their value.
         s_axi_bresp <= hit_w ? `BSM_RESP_OKAY : `BSM_RESP_SLVERR;
      end else if (b_fire) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Interrupt mask
   // ------------------------------------------------------------
   always @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         irq_mask_r <= {`BSM_IRQ_W{1'b0}};
      end else if (mask_wr) begin
         irq_mask_r <= w_eff_data[`BSM_IRQ_W-1:0];
      end
   end

   // ------------------------------------------------------------
   // Erase sequencer
   // ------------------------------------------------------------
   // The request stays up until memory confirms, so a slow erase is never cut short.
   always @* begin
      init_state_nxt = init_state_r;
      init_done_nxt = init_done_r;
      case (init_state_r)
         ST_IDLE: begin
            // Fixed bits are dropped silently; only bit zero starts an erase.
            if (cmd_wr) begin
               init_state_nxt = ST_BUSY;
               init_done_nxt = 1'b0;
            end
         end
         ST_BUSY: begin
            // A second command while busy is ignored; the running erase covers it.
            if (nvm_init_done_in) begin
               // Setting inputs are not touched; new values show after a power cycle.
               init_state_nxt = ST_IDLE;
               init_done_nxt = 1'b1;
            end
         end
         default: begin
            init_state_nxt = ST_IDLE;
         end
      endcase
   end

   always @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         init_state_r <= ST_IDLE;
         init_done_r <= 1'b0;
         nvm_init_req_out <= 1'b0;
      end else begin
         init_state_r <= init_state_nxt;
         init_done_r <= init_done_nxt;
         nvm_init_req_out <= (cmd_wr | init_busy) & ~init_finish;
      end
   end

   // ------------------------------------------------------------
   // Interrupt status
   // ------------------------------------------------------------
   always @* begin
      irq_set = {`BSM_IRQ_W{1'b0}};
      irq_set[`BSM_IRQ_DONE_BIT] = init_finish;
      irq_set[`BSM_IRQ_CMD_BIT] = cmd_wr;
      irq_clr = {`BSM_IRQ_W{1'b0}};
      if (stat_wr) begin
         irq_clr = w_eff_data[`BSM_IRQ_W-1:0];
      end
      // Set wins over a clear written in the same cycle, so no event is lost.
      irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_set;
   end

   always @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         irq_stat_r <= {`BSM_IRQ_W{1'b0}};
         irq_out <= 1'b0;
      end else begin
         irq_stat_r <= irq_stat_nxt;
         // Built from the next status so the line follows the bit without a lag.
         irq_out <= |(irq_stat_nxt & irq_mask_r);
      end
   end

   // ------------------------------------------------------------
   // Read-back words
   // ------------------------------------------------------------
   wire [ADDR_W-3:0] rd_idx;
   wire [NUM_FLAGS-1:0] flag_bits;
   wire [16*NUM_FLAGS-1:0] flag_words;
   wire [15:0] cycles_word;
   wire [15:0] dbl_word;
   wire ar_fire;
   wire r_fire;
   reg [15:0] rd_word;
   reg rd_hit;

   assign rd_idx = s_axi_araddr[ADDR_W-1:2];
   assign ar_fire = s_axi_arvalid & s_axi_arready;
   assign r_fire = s_axi_rvalid & s_axi_rready;
   assign flag_bits[FLAG_STARTUP] = startup_collect_in;
   assign flag_bits[FLAG_AUTO_RECOV] = auto_recovery_in;
   assign flag_bits[FLAG_IN_POLICY] = word_in_hold_in;
   assign flag_bits[FLAG_OUT_POLICY] = out_hold_in;
   assign flag_bits[FLAG_EASY_SWAP] = easy_swap_disable_in;
   // The cycle count reads zero whenever word transmission is off.
   assign cycles_word = word_tx_used_in ? word_cycles_in : 16'h0000;
   // 0000 and 0020 both mean every word; 0001..001f cover words 1..n; larger reads 0000.
   assign dbl_word = (dbl_check_in > `BSM_DBL_MAX) ? `BSM_DBL_ALL_A : dbl_check_in;

   // Each one-bit setting reads back as a whole word, zero or one.
   genvar gi;
   generate
      for (gi = 0; gi < NUM_FLAGS; gi = gi + 1) begin : g_flag
         assign flag_words[16*gi +: 16] = {15'h0000, flag_bits[gi]};
      end
   endgenerate

   // ------------------------------------------------------------
   // Read decode
   // ------------------------------------------------------------
   always @* begin
      rd_word = 16'h0000;
      rd_hit = 1'b1;
      case (rd_idx)
         `BSM_IDX_WORD_CYCLES: begin
            rd_word = cycles_word;
         end
         `BSM_IDX_STARTUP: begin
            rd_word = flag_words[16*FLAG_STARTUP +: 16];
         end
         `BSM_IDX_DBL_CHECK: begin
            rd_word = dbl_word;
         end
         `BSM_IDX_AUTO_RECOV: begin
            rd_word = flag_words[16*FLAG_AUTO_RECOV +: 16];
         end
         `BSM_IDX_IN_POLICY: begin
            rd_word = flag_words[16*FLAG_IN_POLICY +: 16];
         end
         `BSM_IDX_OUT_POLICY: begin
            rd_word = flag_words[16*FLAG_OUT_POLICY +: 16];
         end
         `BSM_IDX_EASY_SWAP: begin
            rd_word = flag_words[16*FLAG_EASY_SWAP +: 16];
         end
         `BSM_IDX_INIT_CMD: begin
            // Reads one while the erase runs and drops back to zero when it ends.
            rd_word = {15'h0000, init_busy};
         end
         `BSM_IDX_INIT_DONE: begin
            rd_word = {15'h0000, init_done_r};
         end
         `BSM_IDX_IRQ_STATUS: begin
            rd_word = {{(16-`BSM_IRQ_W){1'b0}}, irq_stat_r};
         end
         `BSM_IDX_IRQ_MASK: begin
            rd_word = {{(16-`BSM_IRQ_W){1'b0}}, irq_mask_r};
         end
         default: begin
            rd_hit = 1'b0;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Read response
   // ------------------------------------------------------------
   always @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `BSM_RESP_OKAY;
      end else if (ar_fire) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         // Live inputs are captured here, so the data stands unchanged until taken.
         s_axi_rdata <= {16'h0000, rd_word};
         s_axi_rresp <= rd_hit ? `BSM_RESP_OKAY : `BSM_RESP_SLVERR;
      end else begin
         // An address is taken only when no read data is waiting.
         s_axi_arready <= ~s_axi_rvalid;
         if (r_fire) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule // bsm_setting_monitor_bank
`default_nettype wire

// ===== bsm_defs.vh
// Constants for the bridge setting monitor bank.
`ifndef BSM_DEFS_VH
`define BSM_DEFS_VH
// Register indices; the byte address is four times the index.
`define BSM_IDX_WORD_CYCLES 12'h315
`define BSM_IDX_STARTUP 12'h316
`define BSM_IDX_DBL_CHECK 12'h317
`define BSM_IDX_AUTO_RECOV 12'h318
`define BSM_IDX_IN_POLICY 12'h319
`define BSM_IDX_OUT_POLICY 12'h31a
`define BSM_IDX_EASY_SWAP 12'h31b
`define BSM_IDX_INIT_CMD 12'h402
`define BSM_IDX_INIT_DONE 12'h403
`define BSM_IDX_IRQ_STATUS 12'h404
`define BSM_IDX_IRQ_MASK 12'h405
// Field values.
`define BSM_CMD_BIT 0
`define BSM_DBL_ALL_A 16'h0000
`define BSM_DBL_ALL_B 16'h0020
`define BSM_DBL_MAX 16'h0020
`define BSM_RESP_OKAY 2'b00
`define BSM_RESP_SLVERR 2'b10
// Interrupt status bits.
`define BSM_IRQ_DONE_BIT 0
`define BSM_IRQ_CMD_BIT 1
`define BSM_IRQ_W 2
`endif

// ===== bsm_props.sv
// Port checks for the setting monitor bank.
`timescale 1ns/1ps
`default_nettype none
module bsm_props (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic nvm_init_req_out,
   input wire logic nvm_init_done_in
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   sequence r_end; s_axi_rvalid && s_axi_rready; endsequence
   sequence b_end; s_axi_bvalid && s_axi_bready; endsequence
   chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read late");
   chk_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
      else $error("upper half set");
   chk_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("ar open");
   chk_aw_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("aw open");
   chk_rd_close: assert property (r_end |=> !s_axi_rvalid ##1 s_axi_arready)
      else $error("read close");
   chk_wr_close: assert property (b_end |=> !s_axi_bvalid ##1 (s_axi_awready && s_axi_wready))
      else $error("write close");
   // The request must stay up until memory confirms, or the erase may be cut short.
   chk_req_hold: assert property (nvm_init_req_out && !nvm_init_done_in |=> nvm_init_req_out)
      else $error("req dropped");
   chk_req_drop: assert property (nvm_init_req_out && nvm_init_done_in |=> !nvm_init_req_out)
      else $error("req stuck");
endmodule // bsm_props
`default_nettype wire

// ===== bsm_nvm_model.sv
// Behavioural non-volatile memory answering the erase request.
`timescale 1ns/1ps
`default_nettype none
module bsm_nvm_model (
   input wire logic ref_clk_in,
   input wire logic req_in,
   output logic done_out
);
   initial begin
      done_out = 1'b0;
      forever begin
         @(posedge ref_clk_in);
         if (req_in) begin
            // Erase time is drawn at random, one to eight cycles, for each request.
            repeat ($urandom_range(8, 1)) @(posedge ref_clk_in);
            done_out <= 1'b1;
            @(posedge ref_clk_in);
            done_out <= 1'b0;
         end
      end
   end
endmodule // bsm_nvm_model
`default_nettype wire

// ===== test_bsm_setting_monitor_bank.sv
// Self-checking bench for the setting monitor bank.
`timescale 1ns/1ps
`default_nettype none
module test_bsm_setting_monitor_bank;
   logic ref_clk_in = 1'b0, rst_in = 1'b1, word_tx_used_in = 1'b0, startup_collect_in = 1'b0;
   logic auto_recovery_in = 1'b0, word_in_hold_in = 1'b0, out_hold_in = 1'b0;
   logic easy_swap_disable_in = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [15:0] word_cycles_in = 16'h0, dbl_check_in = 16'h0, s_axi_awaddr = 16'h0;
   logic [15:0] s_axi_araddr = 16'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic nvm_init_done_in, nvm_init_req_out, irq_out, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [33:0] exp_q[$];
   logic [15:0] dbl_tab[5] = '{16'h0020, 16'h001f, 16'h0001, 16'h0000, 16'h0021};
   int mismatches = 0, total_checks = 0;
   bsm_setting_monitor_bank i_bsm_setting_monitor_bank (.*);
   bsm_nvm_model i_bsm_nvm_model (
      .ref_clk_in(ref_clk_in),
      .req_in(nvm_init_req_out),
      .done_out(nvm_init_done_in)
   );
   initial forever #4 ref_clk_in = ~ref_clk_in;
   task automatic chk(input logic [33:0] e, input logic [33:0] g);
      total_checks++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic irq_is(input logic e);
      @(posedge ref_clk_in);
      chk({33'h0, e}, {33'h0, irq_out});
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge ref_clk_in);
      exp_q.push_back(34'h0);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge ref_clk_in);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [33:0] e);
      @(posedge ref_clk_in);
      exp_q.push_back(e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge ref_clk_in);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
   endtask
   // Responses arrive in request order, so the oldest note always matches.
   always @(posedge ref_clk_in) begin
      if (s_axi_bvalid && s_axi_bready) chk(exp_q.pop_front(), {s_axi_bresp, 32'h0});
      if (s_axi_rvalid && s_axi_rready) chk(exp_q.pop_front(), {s_axi_rresp, s_axi_rdata});
   end
   task automatic end_sim;
      $display("checks=%0d mismatches=%0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      void'($urandom(9));
      repeat (20) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      rd(16'h1008, 34'h0);
      rd(16'h100c, 34'h0);
      rd(16'h0000, {2'b10, 32'h0});
      for (int i = 0; i < 7; i++) begin
         word_tx_used_in <= i[0];
         {startup_collect_in, auto_recovery_in, word_in_hold_in, out_hold_in} <= 4'($urandom);
         easy_swap_disable_in <= ~i[1];
         word_cycles_in <= 16'($urandom);
         dbl_check_in <= (i < 5) ? dbl_tab[i] : 16'($urandom_range(63));
         @(posedge ref_clk_in);
         rd(16'hc54, {18'h0, word_tx_used_in ? word_cycles_in : 16'h0});
         rd(16'hc58, {33'h0, startup_collect_in});
         rd(16'hc5c, {18'h0, dbl_check_in > 16'h0020 ? 16'h0 : dbl_check_in});
         rd(16'hc60, {33'h0, auto_recovery_in});
         rd(16'hc64, {33'h0, word_in_hold_in});
         rd(16'hc68, {33'h0, out_hold_in});
         rd(16'hc6c, {33'h0, easy_swap_disable_in});
      end
      wr(16'hc54, $urandom);
      rd(16'hc54, {18'h0, word_tx_used_in ? word_cycles_in : 16'h0});
      $display("read-back tests done");
      wr(16'h1014, 32'h0);
      wr(16'h1008, 32'h0000ffff);
      chk(34'h1, {33'h0, nvm_init_req_out});
      for (int n = 0; n < 40 && nvm_init_req_out; n++) @(posedge ref_clk_in);
      rd(16'h100c, 34'h1);
      rd(16'h1008, 34'h0);
      rd(16'h1010, 34'h3);
      irq_is(1'b0);
      wr(16'h1014, 32'h3);
      irq_is(1'b1);
      wr(16'h1010, 32'h3);
      irq_is(1'b0);
      rd(16'h1010, 34'h0);
      $display("init and interrupt tests done");
      end_sim;
   end
   initial begin
      #100000;
      mismatches++;
      end_sim;
   end
endmodule // test_bsm_setting_monitor_bank
bind bsm_setting_monitor_bank bsm_props i_bsm_props (.*);
`default_nettype wire
